/* verilog/uhm_pkg.sv */
// shared constants and types of the hub microcontroller i/o register bank
//
// Notes on behaviour
// - offset 0x04: eight write-only port 0 pin interrupt enables, cleared at reset
// - offset 0x05: port 1 pin interrupt enables, bit 3 reserved, cleared at reset
// - offset 0x1F: size, mode, activity, control bits; bits 5:4 read upstream lines
// - offset 0x10: bit 7 enables, bits 6:0 hold the address; resets disabled
// - offset 0x08: two-bit drive field per port 0 and 1, upper bits reserved
// - counters hold toggle, valid, six-bit count; modes hold ack and four-bit mode
package uhm_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_PORT0 = 8'h00;
  localparam logic [7:0] IDX_PORT1 = 8'h01;
  localparam logic [7:0] IDX_PORT2 = 8'h02;
  localparam logic [7:0] IDX_PORT3 = 8'h03;
  localparam logic [7:0] IDX_P0_IRQ_MASK = 8'h04;
  localparam logic [7:0] IDX_P1_IRQ_MASK = 8'h05;
  localparam logic [7:0] IDX_DRIVE_CFG = 8'h08;
  localparam logic [7:0] IDX_PAR_TW_CFG = 8'h09;
  localparam logic [7:0] IDX_FUNC_ADDR = 8'h10;
  localparam logic [7:0] IDX_CTRL_CNT = 8'h11;
  localparam logic [7:0] IDX_CTRL_MODE = 8'h12;
  localparam logic [7:0] IDX_D1_CNT = 8'h13;
  localparam logic [7:0] IDX_D1_MODE = 8'h14;
  localparam logic [7:0] IDX_D2_CNT = 8'h15;
  localparam logic [7:0] IDX_D2_MODE = 8'h16;
  localparam logic [7:0] IDX_LINK_SC = 8'h1f;
  localparam logic [7:0] IDX_GLB_MASK = 8'h20;
  localparam logic [7:0] IDX_EP_MASK = 8'h21;
  localparam logic [7:0] IDX_TMR_LO = 8'h24;
  localparam logic [7:0] IDX_TMR_HI = 8'h25;
  localparam logic [7:0] IDX_GLB_STAT = 8'h30;
  localparam logic [7:0] IDX_EP_STAT = 8'h31;

  // ****************************************************************
  // reset values and writable-bit masks
  // ****************************************************************
  localparam logic [7:0] RST_PORT_DATA = 8'hff;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] P1_IRQ_VALID = 8'hf7;
  localparam logic [7:0] DRIVE_CFG_VALID = 8'h0f;
  localparam logic [7:0] PAR_TW_VALID = 8'h82;
  localparam logic [7:0] LINK_SC_VALID = 8'hcf;
  localparam logic [7:0] GLB_VALID = 8'h6f;
  localparam logic [7:0] EP_VALID = 8'h1f;
  localparam logic [7:0] DATA_MODE_VALID = 8'h9f;
  localparam logic [7:0] TMR_HI_VALID = 8'h0f;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int GIRQ_BUS_RESET = 0;
  localparam int GIRQ_FAST = 1;
  localparam int GIRQ_SLOW = 2;
  localparam int GIRQ_HUB = 3;
  localparam int GIRQ_GPIO = 5;
  localparam int GIRQ_TWI = 6;
  localparam int LSC_DP = 5;
  localparam int LSC_DM = 4;
  localparam int LSC_ACT = 3;
  localparam int FADDR_EN = 7;
  localparam int MODE_SETUP = 7;
  localparam int MODE_STALL = 7;
  localparam int P0_CFG_LSB = 0;
  localparam int P1_CFG_LSB = 2;

  // drive configuration encodings
  localparam logic [1:0] DRV_OPEN_DRAIN = 2'h0;
  localparam logic [1:0] DRV_CMOS = 2'h1;
  localparam logic [1:0] DRV_INPUT = 2'h2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 12;
  localparam int FAST_PERIOD_US = 128;
  localparam int SLOW_PERIOD_US = 1024;

  // ****************************************************************
  // state of the register bank
  // ****************************************************************
  typedef struct packed {
    logic [3:0][7:0] port_data;
    logic [1:0][7:0] pin_irq_mask;
    logic [1:0][7:0] pin_prev;
    logic [7:0] drive_cfg;
    logic [7:0] par_tw_cfg;
    logic [7:0] func_addr;
    logic [2:0][7:0] ep_count;
    logic [2:0][7:0] ep_mode;
    logic [7:0] link_sc;
    logic [7:0] glb_mask;
    logic [7:0] ep_mask;
    logic [7:0] glb_stat;
    logic [7:0] ep_stat;
    logic [31:0] prdata;
    logic ack;
    logic err;
  } uhm_regs_state_t;

endpackage

/* verilog/uhm_timer_if.sv */
// carrier between the free-running timer and the register bank
`timescale 1ns/1ns
`default_nettype none
interface uhm_timer_if;
  logic [uhm_pkg::TMR_W-1:0] count;
  logic tick_fast;
  logic tick_slow;

  modport src (output count, output tick_fast, output tick_slow);
  modport snk (input count, input tick_fast, input tick_slow);
endinterface
`default_nettype wire

/* verilog/uhm_free_timer.sv */
// twelve-bit free-running microsecond timer with periodic ticks
`timescale 1ns/1ns
`default_nettype none
module uhm_free_timer
  import uhm_pkg::*;
#(
  parameter int CLK_NS = CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // timer outputs
  uhm_timer_if.src tmr
);

  localparam int CYC = TICK_PERIOD_NS / CLK_NS;
  localparam int PW = (CYC > 1) ? $clog2(CYC) : 1;

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  generate
    if (CLK_NS < 1 || CYC < 1) begin : g_bad_clk
      $error("clock period too long for a one microsecond tick");
    end
  endgenerate

  typedef struct packed {
    logic [PW-1:0] pre;
    logic [TMR_W-1:0] count;
    logic fast;
    logic slow;
  } uhm_tmr_state_t;

  uhm_tmr_state_t q;
  uhm_tmr_state_t d;
  logic us_tick;

  // prescaler divides the bus clock down to one microsecond
  always_comb begin
    d = q;
    us_tick = (q.pre == PW'(CYC - 1));
    d.pre = us_tick ? '0 : q.pre + 1'b1;
    d.fast = 1'b0;
    d.slow = 1'b0;
    if (us_tick) begin
      d.count = q.count + 1'b1;  // wraps at 4096 us
      d.fast = (q.count[6:0] == 7'(FAST_PERIOD_US - 1));
      d.slow = (q.count[9:0] == 10'(SLOW_PERIOD_US - 1));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tmr.count = q.count;
  assign tmr.tick_fast = q.fast;
  assign tmr.tick_slow = q.slow;

endmodule // uhm_free_timer
`default_nettype wire

/* verilog/uhm_regs.sv */
// apb register bank of the hub microcontroller: gpio, usb function, irq, timer
`timescale 1ns/1ns
`default_nettype none
module uhm_regs
  import uhm_pkg::*;
#(
  parameter int PADDR_W = 12,
  parameter int CLK_NS = CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // gpio pins, four ports of eight
  input wire logic [3:0][7:0] gpio_in,
  output logic [3:0][7:0] gpio_out,
  output logic [3:0][7:0] gpio_oe_n,
  // upstream usb line state and engine events
  input wire logic usb_dp,
  input wire logic usb_dm,
  input wire logic usb_activity,
  input wire logic usb_bus_reset,
  input wire logic hub_event,
  input wire logic twi_event,
  input wire logic [2:0] ep_event,
  input wire logic [2:0] ctrl_token_seen,
  // function, endpoint and link controls
  output logic func_addr_en,
  output logic [6:0] func_addr,
  output logic [2:0][7:0] ep_count,
  output logic [2:0][7:0] ep_mode,
  output logic [7:0] link_ctrl,
  output logic [7:0] par_tw_cfg,
  // interrupt
  output logic irq
);

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  generate
    if (PADDR_W < 10) begin : g_bad_addr
      $error("address bus too narrow for the register map");
    end
  endgenerate

  // ****************************************************************
  // timer
  // ****************************************************************
  uhm_timer_if tmr_if ();

  uhm_free_timer #(
    .CLK_NS(CLK_NS)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .tmr(tmr_if.src)
  );

  // ****************************************************************
  // bus decode
  // ****************************************************************
  uhm_regs_state_t q;
  uhm_regs_state_t d;
  logic [7:0] idx;
  logic aligned;
  logic setup;
  logic wr_take;
  logic [7:0] wb;
  logic [7:0] rd;
  logic hit;
  logic [1:0][7:0] pin_change;
  logic [7:0] glb_ev;
  logic [7:0] ep_ev;

  assign idx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0) && ((paddr >> 10) == '0);
  assign setup = psel && !penable;
  // a write lands only at the completing edge of a good access
  assign wr_take = psel && penable && pwrite && q.ack && !q.err;
  assign wb = pwdata[7:0];

  // read mux; write-only registers read as zero
  always_comb begin
    rd = RST_ZERO;
    hit = aligned;
    case (idx)
      IDX_PORT0: rd = gpio_in[0];
      IDX_PORT1: rd = gpio_in[1];
      IDX_PORT2: rd = gpio_in[2];
      IDX_PORT3: rd = gpio_in[3];
      IDX_P0_IRQ_MASK: rd = RST_ZERO;
      IDX_P1_IRQ_MASK: rd = RST_ZERO;
      IDX_DRIVE_CFG: rd = q.drive_cfg;
      IDX_PAR_TW_CFG: rd = q.par_tw_cfg;
      IDX_FUNC_ADDR: rd = q.func_addr;
      IDX_CTRL_CNT: rd = q.ep_count[0];
      IDX_CTRL_MODE: rd = q.ep_mode[0];
      IDX_D1_CNT: rd = q.ep_count[1];
      IDX_D1_MODE: rd = q.ep_mode[1];
      IDX_D2_CNT: rd = q.ep_count[2];
      IDX_D2_MODE: rd = q.ep_mode[2];
      IDX_LINK_SC: begin
        rd = q.link_sc;
        rd[LSC_DP] = usb_dp;
        rd[LSC_DM] = usb_dm;
      end
      IDX_GLB_MASK: rd = q.glb_mask;
      IDX_EP_MASK: rd = q.ep_mask;
      IDX_TMR_LO: rd = tmr_if.count[7:0];
      IDX_TMR_HI: rd = {4'h0, tmr_if.count[TMR_W-1:8]};
      IDX_GLB_STAT: rd = q.glb_stat;
      IDX_EP_STAT: rd = q.ep_stat;
      default: hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // event sources
  // ****************************************************************
  // pin change on an enabled pin; inputs are already synchronous
  always_comb begin
    pin_change[0] = (gpio_in[0] ^ q.pin_prev[0]) & q.pin_irq_mask[0];
    pin_change[1] = (gpio_in[1] ^ q.pin_prev[1]) & q.pin_irq_mask[1];
  end

  // global events in the layout of the global mask
  always_comb begin
    glb_ev = RST_ZERO;
    glb_ev[GIRQ_BUS_RESET] = usb_bus_reset;
    glb_ev[GIRQ_FAST] = tmr_if.tick_fast;
    glb_ev[GIRQ_SLOW] = tmr_if.tick_slow;
    glb_ev[GIRQ_HUB] = hub_event;
    glb_ev[GIRQ_GPIO] = |pin_change;
    glb_ev[GIRQ_TWI] = twi_event;
    ep_ev = {5'h00, ep_event};
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.err = 1'b0;
    d.pin_prev[0] = gpio_in[0];
    d.pin_prev[1] = gpio_in[1];
    // read data and error are latched in setup so they come from flops
    if (setup) begin
      d.ack = 1'b1;
      d.err = !hit;
      d.prdata = {24'h00_0000, (pwrite || !hit) ? RST_ZERO : rd};
    end
    if (wr_take) begin
      case (idx)
        IDX_PORT0: d.port_data[0] = wb;
        IDX_PORT1: d.port_data[1] = wb;
        IDX_PORT2: d.port_data[2] = wb;
        IDX_PORT3: d.port_data[3] = wb;
        IDX_P0_IRQ_MASK: d.pin_irq_mask[0] = wb;
        IDX_P1_IRQ_MASK: d.pin_irq_mask[1] = wb & P1_IRQ_VALID;
        IDX_DRIVE_CFG: d.drive_cfg = wb & DRIVE_CFG_VALID;
        IDX_PAR_TW_CFG: d.par_tw_cfg = wb & PAR_TW_VALID;
        IDX_FUNC_ADDR: d.func_addr = wb;
        IDX_CTRL_CNT: d.ep_count[0] = wb;
        IDX_CTRL_MODE: d.ep_mode[0] = wb;
        IDX_D1_CNT: d.ep_count[1] = wb;
        IDX_D1_MODE: d.ep_mode[1] = wb & DATA_MODE_VALID;
        IDX_D2_CNT: d.ep_count[2] = wb;
        IDX_D2_MODE: d.ep_mode[2] = wb & DATA_MODE_VALID;
        IDX_LINK_SC: d.link_sc = wb & LINK_SC_VALID;
        IDX_GLB_MASK: d.glb_mask = wb & GLB_VALID;
        IDX_EP_MASK: d.ep_mask = wb & EP_VALID;
        // status bits clear on a written one
        IDX_GLB_STAT: d.glb_stat = q.glb_stat & ~wb;
        IDX_EP_STAT: d.ep_stat = q.ep_stat & ~wb;
        default: d.prdata = q.prdata;
      endcase
    end
    // hardware sets come after the write so a set in the clear cycle wins
    d.ep_mode[0][MODE_SETUP -: 3] = d.ep_mode[0][MODE_SETUP -: 3] | ctrl_token_seen;
    d.link_sc[LSC_ACT] = d.link_sc[LSC_ACT] | usb_activity;
    d.glb_stat = d.glb_stat | glb_ev;
    d.ep_stat = d.ep_stat | ep_ev;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.port_data <= {4{RST_PORT_DATA}};
      q.pin_prev <= {2{RST_PORT_DATA}};
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // apb answer
  // ****************************************************************
  // zero wait states: the access phase completes in its first cycle
  assign pready = psel && penable && q.ack;
  assign pslverr = psel && penable && q.err;
  assign prdata = q.prdata;

  // ****************************************************************
  // pin drivers
  // ****************************************************************
  // ports 2 and 3 have no drive field and stay open drain
  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_port
      logic [1:0] cfg;
      if (gp == 0) begin : g_p0
        assign cfg = q.drive_cfg[P0_CFG_LSB +: 2];
      end else if (gp == 1) begin : g_p1
        assign cfg = q.drive_cfg[P1_CFG_LSB +: 2];
      end else begin : g_px
        assign cfg = DRV_OPEN_DRAIN;
      end
      assign gpio_out[gp] = q.port_data[gp];
      // open drain only pulls low, a one lets the pull-up win
      assign gpio_oe_n[gp] = (cfg == DRV_CMOS) ? 8'h00 :
                             (cfg == DRV_INPUT) ? 8'hff : q.port_data[gp];
    end
  endgenerate

  // ****************************************************************
  // block outputs
  // ****************************************************************
  assign func_addr_en = q.func_addr[FADDR_EN];
  assign func_addr = q.func_addr[6:0];
  assign ep_count = q.ep_count;
  assign ep_mode = q.ep_mode;
  assign link_ctrl = q.link_sc;
  assign par_tw_cfg = q.par_tw_cfg;
  // level interrupt while any unmasked status bit is set
  assign irq = |(q.glb_stat & q.glb_mask) || |(q.ep_stat & q.ep_mask);

endmodule // uhm_regs
`default_nettype wire

/* verification/uhm_usb_host_model.sv */
// stand-in for the upstream usb host: line levels, tokens, bus reset
`timescale 1ns/1ns
`default_nettype none
module uhm_usb_host_model (
  // clock
  input wire logic pclk,
  // upstream lines and engine pulses
  output logic usb_dp,
  output logic usb_dm,
  output logic usb_activity,
  output logic usb_bus_reset,
  output logic [2:0] ctrl_token_seen
);
  // idle link rests in the full speed j state
  initial begin
    usb_dp = 1'b1;
    usb_dm = 1'b0;
    usb_activity = 1'b0;
    usb_bus_reset = 1'b0;
    ctrl_token_seen = 3'h0;
  end
  // new line levels just after an edge
  task automatic lines(input logic dp, input logic dm);
    @(posedge pclk);
    usb_dp <= dp;
    usb_dm <= dm;
  endtask
  // k 0..2 out, in, setup token; 3 a bus reset; always one cycle of activity
  task automatic token(input int k);
    @(posedge pclk);
    ctrl_token_seen <= 3'h1 << k;
    usb_bus_reset <= (k == 3);
    usb_activity <= 1'b1;
    @(posedge pclk);
    ctrl_token_seen <= 3'h0;
    usb_bus_reset <= 1'b0;
    usb_activity <= 1'b0;
  endtask
endmodule // uhm_usb_host_model
`default_nettype wire

/* verification/uhm_regs_properties.sv */
// port assertions of the hub microcontroller register bank
`timescale 1ns/1ns
`default_nettype none
module uhm_regs_properties
  import uhm_pkg::*;
#(
  parameter int PADDR_W = 12
) (
  // clock, reset, bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // usb side and outputs
  input wire logic usb_dp,
  input wire logic usb_dm,
  input wire logic usb_activity,
  input wire logic [2:0] ctrl_token_seen,
  input wire logic func_addr_en,
  input wire logic [6:0] func_addr,
  input wire logic [2:0][7:0] ep_count,
  input wire logic [2:0][7:0] ep_mode,
  input wire logic [7:0] link_ctrl,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // read setup and write access phases
  logic rd_s;
  logic wr_a;
  assign rd_s = psel && !penable && !pwrite;
  assign wr_a = psel && penable && pwrite;
  // ****************************************************************
  // assertions
  // ****************************************************************
  AST_ZERO_WAIT: assert property (pready == (psel && penable))
    else $error("pready not in first access cycle");
  AST_FADDR_FIELDS: assert property (
    wr_a && paddr == 12'h040 |=> func_addr_en == $past(pwdata[7]) &&
    func_addr == $past(pwdata[6:0])) else $error("function address fields wrong");
  AST_EP_COUNT: assert property (
    wr_a && paddr == 12'h044 |=> ep_count[0] == $past(pwdata[7:0]))
    else $error("endpoint counter not stored");
  AST_WO_READ: assert property (
    rd_s && (paddr == 12'h010 || paddr == 12'h014) |=> prdata == 32'h0)
    else $error("write-only mask read nonzero");
  AST_LINE_LEVELS: assert property (
    rd_s && paddr == 12'h07c |=> prdata[5] == $past(usb_dp) && prdata[4] == $past(usb_dm))
    else $error("line levels misread");
  AST_LINK_STORE: assert property (
    wr_a && paddr == 12'h07c && !usb_activity |=> link_ctrl == ($past(pwdata[7:0]) & 8'hcf))
    else $error("link control store wrong");
  AST_DRIVE_RSV: assert property (
    rd_s && paddr == 12'h020 |=> prdata[31:4] == 28'h000_0000)
    else $error("drive config reserved bits set");
  AST_DATA_MODE_RSV: assert property (
    rd_s && (paddr == 12'h050 || paddr == 12'h058) |=> prdata[6:5] == 2'h0)
    else $error("data mode bits 6:5 set");
  AST_TOKEN_FLAG: assert property (
    ctrl_token_seen != 3'h0 |=>
    (ep_mode[0][7:5] & $past(ctrl_token_seen)) == $past(ctrl_token_seen))
    else $error("token flag not raised");
  AST_UNMAPPED: assert property (psel && penable && paddr == 12'h018 |-> pslverr)
    else $error("unmapped access without error");
  // main scenarios reached
  COV_IRQ: cover property ($rose(irq));
  COV_ERR: cover property (pready && pslverr);
  COV_TOKEN: cover property (ctrl_token_seen[2]);
endmodule // uhm_regs_properties
bind uhm_regs uhm_regs_properties #(.PADDR_W(PADDR_W)) uhm_regs_properties_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .usb_dp, .usb_dm, .usb_activity, .ctrl_token_seen, .func_addr_en,
  .func_addr, .ep_count, .ep_mode, .link_ctrl, .irq);
`default_nettype wire

/* verification/uhm_regs_test.sv */
// self-checking bench of the hub microcontroller register bank
`timescale 1ns/1ns
`default_nettype none
module uhm_regs_test
  import uhm_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic usb_dp, usb_dm, usb_activity, usb_bus_reset, func_addr_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0][7:0] gpio_in, gpio_out, gpio_oe_n;
  logic [2:0] ctrl_token_seen;
  logic [4:0] ev;
  logic [6:0] func_addr;
  logic [2:0][7:0] ep_count, ep_mode;
  logic [7:0] link_ctrl, par_tw_cfg;
  int n_errors, samples_checked;
  // fast prescale: timer steps every two clocks
  uhm_regs #(.CLK_NS(500)) uhm_regs_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .gpio_in, .gpio_out, .gpio_oe_n,
    .usb_dp, .usb_dm, .usb_activity, .usb_bus_reset, .hub_event(ev[4]),
    .twi_event(ev[3]), .ep_event(ev[2:0]), .ctrl_token_seen, .func_addr_en,
    .func_addr, .ep_count, .ep_mode, .link_ctrl, .par_tw_cfg, .irq);
  uhm_usb_host_model uhm_usb_host_model_inst (.pclk, .usb_dp, .usb_dm, .usb_activity,
    .usb_bus_reset, .ctrl_token_seen);
  // ****************************************************************
  // bus and compare tasks
  // ****************************************************************
  task automatic close_out;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // callers come back at a falling edge, so the value passed in has settled
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask
  // one apb transfer; the wait for pready is bounded
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      close_out;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // hand back at the falling edge so callers see settled outputs
    @(negedge pclk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
                       input logic [31:0] m = 32'hffff_ffff);
    apb(1'b0, a, 32'h0);
    chk_val(rd & m, e);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    int i;
    chk_val({16'h0, gpio_oe_n[1:0]}, 32'h0000_ffff);
    chk_bit(func_addr_en, 1'b0);
    rdchk(12'h040, 32'h0);
    rdchk(12'h020, 32'h0);
    for (i = 0; i < 6; i++) rdchk(12'(12'h044 + 4 * i), 32'h0);
    rdchk(12'h080, 32'h0);
    rdchk(12'h084, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_fields;
    int i;
    apb(1'b1, 12'h040, 32'h0000_01a5);
    chk_bit(func_addr_en, 1'b1);
    chk_val({25'h0, func_addr}, 32'h25);
    rdchk(12'h040, 32'ha5);
    apb(1'b1, 12'h020, 32'h5);
    chk_val({16'h0, gpio_oe_n[1:0]}, 32'h0);
    apb(1'b1, 12'h020, 32'hff);
    rdchk(12'h020, 32'hf);
    apb(1'b1, 12'h000, 32'h5a);
    chk_val({16'h0, gpio_out[0], gpio_oe_n[0]}, 32'h5a5a);
    apb(1'b1, 12'h024, 32'hff);
    chk_val({24'h0, par_tw_cfg}, 32'h82);
    rdchk(12'h024, 32'h82);
    for (i = 0; i < 3; i++) begin
      apb(1'b1, 12'(12'h044 + 8 * i), 32'h0000_01ff);
      apb(1'b1, 12'(12'h048 + 8 * i), 32'hff);
      chk_val({24'h0, ep_count[i]}, 32'hff);
      rdchk(12'(12'h048 + 8 * i), (i == 0) ? 32'hff : 32'h9f);
    end
    $display("t_fields done");
  endtask
  task automatic t_link;
    uhm_usb_host_model_inst.lines(1'b1, 1'b0);
    uhm_usb_host_model_inst.token(0);
    apb(1'b1, 12'h07c, 32'hc7); // bit 3 written low clears activity
    chk_val({24'h0, link_ctrl}, 32'hc7);
    rdchk(12'h07c, 32'he7);
    uhm_usb_host_model_inst.token(1);
    uhm_usb_host_model_inst.lines(1'b0, 1'b1);
    rdchk(12'h07c, 32'hdf);
    $display("t_link done");
  endtask
  task automatic t_token;
    int k;
    apb(1'b1, 12'h048, 32'h0);
    for (k = 0; k < 3; k++) uhm_usb_host_model_inst.token(k);
    rdchk(12'h048, 32'he0);
    chk_val({24'h0, ep_mode[0]}, 32'he0);
    $display("t_token done");
  endtask
  // irq waits up to twenty cycles for the pin change to reach the global status
  task automatic wait_irq;
    int i;
    for (i = 0; i < 20 && irq !== 1'b1; i++) @(negedge pclk);
    chk_bit(irq, 1'b1);
  endtask
  task automatic t_irq;
    apb(1'b1, 12'h0c0, 32'hff);
    apb(1'b1, 12'h0c4, 32'hff);
    apb(1'b1, 12'h080, 32'h20);
    apb(1'b1, 12'h014, 32'hff);
    apb(1'b1, 12'h010, 32'h80);
    rdchk(12'h010, 32'h0);
    rdchk(12'h014, 32'h0);
    @(posedge pclk);
    gpio_in[1][3] <= 1'b1; // reserved pin
    gpio_in[0][6] <= 1'b1; // masked pin
    repeat (8) @(posedge pclk);
    rdchk(12'h0c0, 32'h0, 32'h20);
    @(posedge pclk);
    gpio_in[0][7] <= 1'b1;
    wait_irq;
    apb(1'b1, 12'h0c0, 32'h20);
    chk_bit(irq, 1'b0);
    @(posedge pclk);
    gpio_in[1][2] <= 1'b1;
    wait_irq;
    apb(1'b1, 12'h0c0, 32'h20);
    @(posedge pclk);
    ev <= 5'h1f;
    @(posedge pclk);
    ev <= 5'h0;
    uhm_usb_host_model_inst.token(3);
    rdchk(12'h0c0, 32'h49, 32'h69);
    rdchk(12'h0c4, 32'h7, 32'h7);
    chk_bit(irq, 1'b0);
    apb(1'b1, 12'h084, 32'h1);
    chk_bit(irq, 1'b1);
    apb(1'b1, 12'h0c4, 32'h7);
    chk_bit(irq, 1'b0);
    // a fast tick comes every 256 clocks at this prescale
    repeat (300) @(posedge pclk);
    rdchk(12'h0c0, 32'h2, 32'h2);
    $display("t_irq done");
  endtask
  task automatic t_err;
    apb(1'b1, 12'h018, 32'hff);
    chk_val({31'h0, er}, 32'h1);
    apb(1'b0, 12'h041, 32'h0);
    chk_val({31'h0, er}, 32'h1);
    chk_val(rd, 32'h0);
    apb(1'b0, 12'h400, 32'h0);
    chk_val({31'h0, er}, 32'h1);
    apb(1'b1, 12'h090, 32'hff);
    chk_val({31'h0, er}, 32'h0);
    rdchk(12'h094, 32'h0, 32'hffff_fff0);
    $display("t_err done");
  endtask
  // ****************************************************************
  // clock and main sequence
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    gpio_in = '0;
    ev = 5'h0;
    n_errors = 0;
    samples_checked = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_fields;
    t_link;
    t_token;
    t_irq;
    t_err;
    close_out;
  end
endmodule // uhm_regs_test
`default_nettype wire
